// ===== logic/pwg_params.svh
// Purpose: constants for the pwm generator counter and fault block
// Assumes: included by the package and the design
// Notes: widths sized for a 16-bit counter
`ifndef PWG_PARAMS_SVH
`define PWG_PARAMS_SVH
`define PWG_CNT_W 16
`define PWG_MINPER_W 16
`define PWG_NFAULT 4
`define PWG_NDCMP 8
`define PWG_RST_LOAD 16'h0000
`define PWG_RST_CMP 16'h0000
`define PWG_RST_DB 12'h000
`define PWG_DB_W 12
`endif

// ===== logic/pwg_pkg.sv
// Purpose: types for the pwm generator counter and fault block
// Assumes: pwg_params.svh holds the numbers
// Notes: sync-timing selection shared by mode and dead-band changes
`include "pwg_params.svh"
package pwg_pkg;
   typedef enum logic [1:0] {
      pwg_sync_none,
      pwg_sync_local,
      pwg_sync_global
   } pwg_sync_e;
   typedef enum logic {
      pwg_cnt_down,
      pwg_cnt_updown
   } pwg_cntmode_e;
   typedef enum logic {
      pwg_dir_down,
      pwg_dir_up
   } pwg_dir_e;
endpackage : pwg_pkg

// ===== logic/pwg_gen.sv
// Purpose: one pwm generator timer/counter with deferred updates and fault logic
// Assumes: pwm_tick is the divided pwm clock enable; inputs synchronous to clock
// Notes: configuration arrives as a one-cycle cfg_wr strobe with the mode ports
// Functional notes
// - down mode counts load to zero, reloads
// - up/down mode counts zero-load-zero repeatedly
// - sync mode holds period/width until sync
// - global sync updates many generators together
// - non-sync mode applies without sync event
// - pending period/width transfer only at zero
// - debug pause: count to zero, hold
// - debug run: keep counting when halted
// - new configuration clears enable for one cycle, then it follows gen_enable
// - mode change timing: none, local, global
// - dead-band change timing: none, local, global
// - faults latched or follow inputs
// - minimum fault period stretches fault signal
// - fault request held during minimum period
// - minimum period in pwm clocks, when enabled
// - per-input programmable fault sense
// - extended or single fault source select
// - disable stops counter advancing
// - enable lets counter advance
// - latched triggers held until software clears
// - single uses input zero; extended ORs triggers
// - status shows live or latched triggers
`timescale 1ns/1ps
module pwg_gen
   import pwg_pkg::*;
#(
   parameter int CNT_W = `PWG_CNT_W,
   parameter int MINPER_W = `PWG_MINPER_W,
   parameter int NFAULT = `PWG_NFAULT,
   parameter int NDCMP = `PWG_NDCMP,
   parameter int DB_W = `PWG_DB_W
) (
   input wire logic clock, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic pwm_tick, // one-cycle pwm clock enable
   input wire logic cfg_wr, // configuration write strobe
   input wire logic cfg_count_updown, // 1 up/down, 0 down
   input wire logic cfg_update_sync, // 1 synchronous parameter update
   input wire logic debug_halt_keep_running, // 1 keep counting on halt
   input wire logic debug_halt_pause_at_zero, // 1 pause at zero on halt
   input wire logic [1:0] cfg_mode_sync, // count-mode change timing
   input wire logic deadtime_change_unsynced, // dead-band timing none, not read; none applies when local and global are both low
   input wire logic deadtime_change_local_sync, // dead-band timing local
   input wire logic deadtime_change_global_sync, // dead-band timing global
   input wire logic fault_follow_input, // 1 unlatched faults
   input wire logic fault_min_duration_on, // minimum fault period on
   input wire logic fault_min_duration_off, // minimum fault period off
   input wire logic fault_source_extended, // extended fault sources
   input wire logic fault_source_single, // single fault input zero
   input wire logic gen_enable, // counter enable level
   input wire logic load_wr, // period write strobe
   input wire logic [CNT_W-1:0] load_wdata, // period value
   input wire logic cmpa_wr, // width a write strobe
   input wire logic cmpb_wr, // width b write strobe
   input wire logic [CNT_W-1:0] cmp_wdata, // width value
   input wire logic db_wr, // dead-band write strobe
   input wire logic [DB_W-1:0] db_rise_wdata, // rising delay
   input wire logic [DB_W-1:0] db_fall_wdata, // falling delay
   input wire logic global_sync_req, // module-level sync request
   input wire logic cpu_halted, // processor halted by debugger
   input wire logic fcfg_wr, // fault config write strobe
   input wire logic [MINPER_W-1:0] minper_wdata, // minimum fault period
   input wire logic [NFAULT-1:0] fault_input_active_high, // 1 high, 0 low
   input wire logic trig_wr, // trigger select write strobe
   input wire logic trig_group, // 0 fault inputs, 1 comparators
   input wire logic [NDCMP-1:0] trig_wdata, // trigger select bits
   input wire logic fclr_wr, // fault clear strobe
   input wire logic fclr_group, // 0 fault inputs, 1 comparators
   input wire logic [NDCMP-1:0] fclr_bits, // triggers to clear
   input wire logic [NFAULT-1:0] fault_in, // external fault inputs
   input wire logic [NDCMP-1:0] dcmp_in, // comparator trigger inputs
   input wire logic stat_group, // status group select
   output logic [NDCMP-1:0] fault_status, // trigger status
   output logic [CNT_W-1:0] count, // counter value
   output logic count_dir_up, // counting up
   output logic [CNT_W-1:0] cmpa_act, // active width a
   output logic [CNT_W-1:0] cmpb_act, // active width b
   output logic [CNT_W-1:0] load_act, // active period
   output logic [DB_W-1:0] db_rise_act, // active rising delay
   output logic [DB_W-1:0] db_fall_act, // active falling delay
   output logic fault_active, // generator fault signal
   output logic fault_irq, // generator fault request
   output logic running // counter enabled
);
   localparam logic [CNT_W-1:0] ZERO = '0;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   pwg_dir_e dir_r, dir_nxt;
   logic en_r;
   pwg_cntmode_e mode_r, mode_pend_r;
   logic mode_pend_v_r;
   pwg_sync_e mode_sync_r, db_sync_r;
   logic upd_sync_r, dbg_run_r;
   logic latch_r, minper_en_r, ext_r;
   logic [CNT_W-1:0] load_r, load_pend_r;
   logic [CNT_W-1:0] cmpa_r, cmpa_pend_r;
   logic [CNT_W-1:0] cmpb_r, cmpb_pend_r;
   logic par_pend_r, par_armed_r;
   logic [DB_W-1:0] dbr_r, dbr_pend_r;
   logic [DB_W-1:0] dbf_r, dbf_pend_r;
   logic db_pend_r, db_armed_r, mode_armed_r, gsync_r;
   logic [MINPER_W-1:0] minper_r, fcnt_r;
   logic [NFAULT-1:0] sense_r;
   logic [NFAULT-1:0] fsel_r;
   logic [NDCMP-1:0] dsel_r;
   // latched trigger bits
   logic [NFAULT-1:0] flat_r;
   logic [NDCMP-1:0] dlat_r;
   logic fhold_r;

   // mode field decodes
   wire pwg_sync_e mode_sync_dec = (cfg_mode_sync == 2'h2) ? pwg_sync_global :
      (cfg_mode_sync == 2'h1) ? pwg_sync_local : pwg_sync_none;
   wire pwg_sync_e db_sync_dec = deadtime_change_global_sync ? pwg_sync_global :
      deadtime_change_local_sync ? pwg_sync_local : pwg_sync_none;
   wire dbg_run_dec = debug_halt_keep_running & ~debug_halt_pause_at_zero;
   wire minper_dec = fault_min_duration_on & ~fault_min_duration_off;
   wire ext_dec = fault_source_extended & ~fault_source_single;
   wire pwg_cntmode_e cntmode_dec = cfg_count_updown ? pwg_cnt_updown : pwg_cnt_down;

   // counter stepping
   // debug pause only bites once the count sits at zero
   wire halt_hold = cpu_halted & ~dbg_run_r & (cnt_r == ZERO);
   wire step = en_r & pwm_tick & ~halt_hold;
   wire at_zero = (cnt_r == ZERO);
   wire zero_evt = step & at_zero;
   wire gsync_seen = gsync_r | global_sync_req;
   // sync decisions
   // sync mode needs a global request, unsynced takes any zero
   wire par_go = zero_evt & par_pend_r & (~upd_sync_r | par_armed_r | gsync_seen);
   wire mode_go = zero_evt & mode_pend_v_r &
      ((mode_sync_r == pwg_sync_none) | (mode_sync_r == pwg_sync_local) |
       (mode_armed_r | gsync_seen));
   // unsynced dead-band skips the zero step entirely
   wire db_now = db_pend_r & (db_sync_r == pwg_sync_none);
   wire db_go = db_now | (zero_evt & db_pend_r &
      ((db_sync_r == pwg_sync_local) | db_armed_r | gsync_seen));
   wire pwg_cntmode_e mode_use = mode_go ? mode_pend_r : mode_r;
   wire [CNT_W-1:0] load_use = par_go ? load_pend_r : load_r;
   // unsynced mode change lands at once only while stopped
   wire mode_none_now = mode_pend_v_r & (mode_sync_r == pwg_sync_none) & ~en_r;

   // next count and direction
   always_comb begin
      cnt_nxt = cnt_r;
      dir_nxt = dir_r;
      if (step) begin
         if (mode_use == pwg_cntmode_e'(pwg_cnt_down)) begin
            dir_nxt = pwg_dir_down;
            cnt_nxt = at_zero ? load_use : cnt_r - 1'b1;
         end else if (at_zero) begin
            dir_nxt = pwg_dir_up;
            cnt_nxt = (load_use == ZERO) ? ZERO : cnt_r + 1'b1;
         end else if (dir_r == pwg_dir_up) begin
            // up/down turns at the active period
            if (cnt_r >= load_r) begin
               dir_nxt = pwg_dir_down;
               cnt_nxt = cnt_r - 1'b1;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   // count and direction registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_r <= ZERO;
         dir_r <= pwg_dir_down;
      end else begin
         cnt_r <= cnt_nxt;
         dir_r <= dir_nxt;
      end
   end

   // configuration and enable
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         en_r <= 1'b0;
         mode_r <= pwg_cnt_down;
         mode_pend_r <= pwg_cnt_down;
         mode_pend_v_r <= 1'b0;
         mode_sync_r <= pwg_sync_none;
         db_sync_r <= pwg_sync_none;
         upd_sync_r <= 1'b0;
         dbg_run_r <= 1'b0;
         latch_r <= 1'b0;
         minper_en_r <= 1'b0;
         ext_r <= 1'b0;
      end else if (cfg_wr) begin
         en_r <= 1'b0;
         mode_pend_r <= cntmode_dec;
         mode_pend_v_r <= 1'b1;
         mode_sync_r <= mode_sync_dec;
         db_sync_r <= db_sync_dec;
         upd_sync_r <= cfg_update_sync;
         dbg_run_r <= dbg_run_dec;
         latch_r <= ~fault_follow_input;
         minper_en_r <= minper_dec;
         ext_r <= ext_dec;
      end else begin
         // enable follows its level one cycle late
         en_r <= gen_enable;
         if (mode_go | mode_none_now) begin
            mode_r <= mode_pend_r;
            mode_pend_v_r <= 1'b0;
         end
      end
   end

   // pending period and width, armed by a global request
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         load_r <= `PWG_RST_LOAD;
         load_pend_r <= `PWG_RST_LOAD;
         cmpa_r <= `PWG_RST_CMP;
         cmpa_pend_r <= `PWG_RST_CMP;
         cmpb_r <= `PWG_RST_CMP;
         cmpb_pend_r <= `PWG_RST_CMP;
         par_pend_r <= 1'b0;
         par_armed_r <= 1'b0;
         mode_armed_r <= 1'b0;
         gsync_r <= 1'b0;
      end else begin
         if (load_wr) begin
            load_pend_r <= load_wdata;
         end
         if (cmpa_wr) begin
            cmpa_pend_r <= cmp_wdata;
         end
         if (cmpb_wr) begin
            cmpb_pend_r <= cmp_wdata;
         end
         if (par_go) begin
            load_r <= load_pend_r;
            cmpa_r <= cmpa_pend_r;
            cmpb_r <= cmpb_pend_r;
         end
         // new writes win over the transfer that clears pending
         par_pend_r <= (load_wr | cmpa_wr | cmpb_wr) | (par_pend_r & ~par_go);
         par_armed_r <= par_pend_r & ~par_go & (par_armed_r | global_sync_req);
         mode_armed_r <= mode_pend_v_r & ~mode_go & (mode_armed_r | global_sync_req);
         // a request one cycle ahead of the zero step still counts
         gsync_r <= global_sync_req & ~zero_evt;
      end
   end

   // dead-band values
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dbr_r <= `PWG_RST_DB;
         dbf_r <= `PWG_RST_DB;
         dbr_pend_r <= `PWG_RST_DB;
         dbf_pend_r <= `PWG_RST_DB;
         db_pend_r <= 1'b0;
         db_armed_r <= 1'b0;
      end else begin
         if (db_wr) begin
            dbr_pend_r <= db_rise_wdata;
            dbf_pend_r <= db_fall_wdata;
         end
         if (db_go) begin
            dbr_r <= dbr_pend_r;
            dbf_r <= dbf_pend_r;
         end
         db_pend_r <= db_wr | (db_pend_r & ~db_go);
         db_armed_r <= db_pend_r & ~db_go & (db_armed_r | global_sync_req);
      end
   end

   // fault triggers
   wire [NFAULT-1:0] fault_adj = ~(fault_in ^ sense_r);
   // single source listens to input zero alone
   wire [NFAULT-1:0] fsel_use = ext_r ? fsel_r : {{(NFAULT-1){1'b0}}, 1'b1};
   wire [NDCMP-1:0] dsel_use = ext_r ? dsel_r : '0;
   wire [NFAULT-1:0] ftrig = fault_adj & fsel_use;
   wire [NDCMP-1:0] dtrig = dcmp_in & dsel_use;
   wire [NFAULT-1:0] fclr_f = (fclr_wr & ~fclr_group) ? fclr_bits[NFAULT-1:0] : '0;
   wire [NDCMP-1:0] fclr_d = (fclr_wr & fclr_group) ? fclr_bits : '0;
   // latched view also passes a live trigger, no cycle lost
   wire [NFAULT-1:0] fview = latch_r ? (flat_r | ftrig) : ftrig;
   wire [NDCMP-1:0] dview = latch_r ? (dlat_r | dtrig) : dtrig;
   wire fault_raw = |fview | |dview;
   wire fcnt_run = fcnt_r != '0;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sense_r <= '0;
         minper_r <= '0;
         fsel_r <= '0;
         dsel_r <= '0;
         flat_r <= '0;
         dlat_r <= '0;
         fcnt_r <= '0;
         fhold_r <= 1'b0;
      end else begin
         if (fcfg_wr) begin
            sense_r <= fault_input_active_high;
            minper_r <= minper_wdata;
         end
         if (trig_wr & ~trig_group) begin
            fsel_r <= trig_wdata[NFAULT-1:0];
         end
         if (trig_wr & trig_group) begin
            dsel_r <= trig_wdata;
         end
         // a live trigger wins over a clear in the same cycle
         flat_r <= ftrig | (flat_r & ~fclr_f);
         dlat_r <= dtrig | (dlat_r & ~fclr_d);
         // timer reloads while the fault stands, runs down on ticks
         if (fault_raw & minper_en_r) begin
            fcnt_r <= minper_r;
            fhold_r <= minper_r != '0;
         end else if (fcnt_run & pwm_tick) begin
            fcnt_r <= fcnt_r - 1'b1;
            fhold_r <= fcnt_r != {{(MINPER_W-1){1'b0}}, 1'b1};
         end else if (~minper_en_r) begin
            fcnt_r <= '0;
            fhold_r <= 1'b0;
         end
      end
   end

   assign fault_active = fault_raw | (minper_en_r & fhold_r);
   assign fault_irq = fault_active;
   assign fault_status = stat_group ? dview : {{(NDCMP-NFAULT){1'b0}}, fview};
   // status and settings straight from registers
   assign count = cnt_r;
   assign count_dir_up = (dir_r == pwg_dir_up);
   assign cmpa_act = cmpa_r;
   assign cmpb_act = cmpb_r;
   assign load_act = load_r;
   assign db_rise_act = dbr_r;
   assign db_fall_act = dbf_r;
   assign running = en_r;
endmodule : pwg_gen

// ===== tb/pwg_far.sv
// Purpose: far side model, pwm clock enable and fault lines
// Assumes: fault_req asks for a fault, sense gives asserted level
// Notes: an idle line shows the inverse of its asserted level
`timescale 1ns/1ps
module pwg_far #(parameter int NFAULT = 4) (
   input wire logic clock, // system clock
   input wire logic sys_rst, // reset, active high
   input wire logic [NFAULT-1:0] fault_req, // faults asked
   input wire logic [NFAULT-1:0] sense, // 1 active high
   output logic pwm_tick, // every second cycle
   output logic [NFAULT-1:0] fault_in // fault lines
);
   logic tick_r;
   assign pwm_tick = tick_r;
   assign fault_in = ~(fault_req ^ sense);
   always_ff @(posedge clock) begin
      tick_r <= sys_rst ? 1'b0 : !tick_r;
   end
endmodule : pwg_far

// ===== tb/pwg_gen_asserts.sv
// Purpose: assertions for the pwm generator block
// Assumes: bound to pwg_gen, one clock domain
// Notes: fault mode bits shadowed from the config strobes
`timescale 1ns/1ps
module pwg_gen_asserts #(parameter int CNT_W = 16, parameter int NFAULT = 4) (
   input wire logic clock, // clock
   input wire logic sys_rst, // reset
   input wire logic pwm_tick, // pwm enable
   input wire logic cfg_wr, // config strobe
   input wire logic fcfg_wr, // fault config strobe
   input wire logic gen_enable, // enable level
   input wire logic fault_source_extended, // extended
   input wire logic fault_source_single, // single
   input wire logic [NFAULT-1:0] fault_input_active_high, // sense
   input wire logic [NFAULT-1:0] fault_in, // fault lines
   input wire logic [CNT_W-1:0] count, // counter
   input wire logic count_dir_up, // direction
   input wire logic [CNT_W-1:0] load_act, // period
   input wire logic running, // enabled
   input wire logic fault_active, // fault
   input wire logic fault_irq // fault request
);
   logic ext_r, sen_r, flt0;
   assign flt0 = fault_in[0] == sen_r;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         {ext_r, sen_r} <= 2'h0;
      end else begin
         ext_r <= cfg_wr ? fault_source_extended & ~fault_source_single : ext_r;
         sen_r <= fcfg_wr ? fault_input_active_high[0] : sen_r;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_CFG_OFF: assert property (cfg_wr |=> !running)
      else $error("running after config write");
   AST_RUN: assert property (!cfg_wr |=> running == $past(gen_enable))
      else $error("running not following enable");
   AST_TICK: assert property (!pwm_tick && !cfg_wr |=> $stable(count))
      else $error("count moved without pwm tick");
   AST_HOLD: assert property (!running && !cfg_wr |=> $stable(count))
      else $error("count moved while disabled");
   AST_DOWN: assert property (running && pwm_tick && !count_dir_up && count != 0
      |=> count == $past(count) - 1) else $error("down step wrong");
   AST_UP: assert property (running && pwm_tick && count_dir_up && count != 0
      && count < load_act |=> count == $past(count) + 1) else $error("up step wrong");
   AST_IRQ: assert property (fault_active |-> fault_irq)
      else $error("fault request low during fault");
   AST_LEG: assert property (!ext_r && flt0 |-> fault_active)
      else $error("input zero fault not signalled");
endmodule : pwg_gen_asserts
bind pwg_gen pwg_gen_asserts #(.CNT_W(CNT_W), .NFAULT(NFAULT)) u_chk (.clock, .sys_rst,
   .pwm_tick, .cfg_wr, .fcfg_wr, .gen_enable, .fault_source_extended, .fault_source_single,
   .fault_input_active_high, .fault_in, .count, .count_dir_up, .load_act, .running,
   .fault_active, .fault_irq);

// ===== tb/pwm_generator_counter_fault_ctrl_tb.sv
// Purpose: self-checking bench for the pwm generator block
// Assumes: pwm_tick from the far-side model every second cycle
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module pwm_generator_counter_fault_ctrl_tb;
   logic clock = 0, sys_rst = 1, pwm_tick, cfg_wr = 0, cfg_count_updown = 0, cfg_update_sync = 0;
   logic debug_halt_keep_running = 0, debug_halt_pause_at_zero = 1, deadtime_change_unsynced = 1;
   logic deadtime_change_local_sync = 0, deadtime_change_global_sync = 0, fault_follow_input = 0;
   logic fault_min_duration_on = 0, fault_min_duration_off = 1, fault_source_extended = 0;
   logic fault_source_single = 1, gen_enable = 0, load_wr = 0, cmpa_wr = 0, cmpb_wr = 0;
   logic db_wr = 0, global_sync_req = 0, cpu_halted = 0, fcfg_wr = 0, trig_wr = 0, fclr_wr = 0;
   logic trig_group = 0, fclr_group = 0, stat_group = 0, count_dir_up, running, fault_active;
   logic fault_irq;
   logic [1:0] cfg_mode_sync = 2'h0;
   logic [3:0] fault_input_active_high = 4'hf, freq = 4'h0, fault_in;
   logic [7:0] trig_wdata = 8'h00, fclr_bits = 8'h01, dcmp_in = 8'h00, fault_status;
   logic [11:0] db_rise_wdata = 12'h000, db_fall_wdata = 12'h000, db_rise_act, db_fall_act;
   logic [15:0] load_wdata = 16'h0000, cmp_wdata = 16'h0000, minper_wdata = 16'h0000, count;
   logic [15:0] cmpa_act, cmpb_act, load_act, c0;
   int n_fail = 0, compares = 0, k;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
`define WAITV(c) begin k = 0; while (!(c) && k < 500) begin cyc(1); k++; end end
   pwg_gen uut (.clock, .sys_rst, .pwm_tick, .cfg_wr, .cfg_count_updown, .cfg_update_sync,
      .debug_halt_keep_running, .debug_halt_pause_at_zero, .cfg_mode_sync,
      .deadtime_change_unsynced, .deadtime_change_local_sync, .deadtime_change_global_sync,
      .fault_follow_input, .fault_min_duration_on, .fault_min_duration_off,
      .fault_source_extended, .fault_source_single, .gen_enable, .load_wr, .load_wdata,
      .cmpa_wr, .cmpb_wr, .cmp_wdata, .db_wr, .db_rise_wdata, .db_fall_wdata, .global_sync_req,
      .cpu_halted, .fcfg_wr, .minper_wdata, .fault_input_active_high, .trig_wr, .trig_group,
      .trig_wdata, .fclr_wr, .fclr_group, .fclr_bits, .fault_in, .dcmp_in, .stat_group,
      .fault_status, .count, .count_dir_up, .cmpa_act, .cmpb_act, .load_act, .db_rise_act,
      .db_fall_act, .fault_active, .fault_irq, .running);
   pwg_far far (.clock, .sys_rst, .fault_req(freq), .sense(fault_input_active_high), .pwm_tick,
      .fault_in);
   always #20 clock = ~clock;
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic cfg(input logic [7:0] m);
      {cfg_count_updown, cfg_update_sync, debug_halt_keep_running, fault_follow_input} = m[7:4];
      {fault_min_duration_on, fault_source_extended} = m[3:2];
      {deadtime_change_local_sync, deadtime_change_global_sync} = m[1:0];
      {debug_halt_pause_at_zero, fault_min_duration_off, fault_source_single} = ~{m[5], m[3:2]};
      deadtime_change_unsynced = m[1:0] == 2'h0;
      cfg_wr = 1;
      cyc(1);
      cfg_wr = 0;
   endtask : cfg
   task automatic par(input logic [15:0] l, input logic [15:0] c);
      {load_wdata, cmp_wdata, load_wr, cmpa_wr, cmpb_wr} = {l, c, 3'h7};
      cyc(1);
      {load_wr, cmpa_wr, cmpb_wr} = 3'h0;
   endtask : par
   task automatic fcfg(input logic [3:0] s, input logic [15:0] p);
      {fault_input_active_high, minper_wdata, fcfg_wr} = {s, p, 1'b1};
      cyc(1);
      fcfg_wr = 0;
   endtask : fcfg
   task automatic test_done;
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   initial begin
      #(40 * 20000);
      n_fail++;
      test_done();
   end
   initial begin
      cyc(12);
      sys_rst = 0;
      fcfg(4'hf, 16'h0000);
      cfg(8'h00);
      par(16'h0005, 16'h0002);
      gen_enable = 1;
      cyc(2);
      `CHK("running", 1'b1, running)
      `WAITV(load_act == 16'h0005)
      `CHK("cmpa_act", 16'h0002, cmpa_act)
      `WAITV(count == 16'h0003)
      par(16'h0007, 16'h0003);
      `WAITV(count == 16'h0001)
      `CHK("load_act", 16'h0005, load_act)
      `WAITV(count == 16'h0007)
      `CHK("load_act", 16'h0007, load_act)
      `CHK("cmpb_act", 16'h0003, cmpb_act)
      gen_enable = 0;
      cyc(2);
      c0 = count;
      cyc(10);
      `CHK("count", c0, count)
      gen_enable = 1;
      cyc(2);
      cfg(8'h80);
      `CHK("running", 1'b0, running)
      par(16'h0004, 16'h0001);
      `WAITV(load_act == 16'h0004)
      `WAITV(count == 16'h0004)
      `CHK("count_dir_up", 1'b1, count_dir_up)
      `WAITV(count == 16'h0003)
      `CHK("count_dir_up", 1'b0, count_dir_up)
      cfg(8'h40);
      par(16'h0006, 16'h0002);
      cyc(60);
      `CHK("load_act", 16'h0004, load_act)
      global_sync_req = 1;
      cyc(1);
      global_sync_req = 0;
      `WAITV(load_act == 16'h0006)
      `CHK("load_act", 16'h0006, load_act)
      cfg(8'h00);
      cpu_halted = 1;
      cyc(40);
      `CHK("count", 16'h0000, count)
      cyc(5);
      `CHK("count", 16'h0000, count)
      cfg(8'h20);
      cyc(2);
      c0 = count;
      cyc(6);
      `CHK("moving", 1'b1, count != c0)
      cpu_halted = 0;
      cfg(8'h00);
      {db_rise_wdata, db_fall_wdata, db_wr} = {12'h003, 12'h005, 1'b1};
      cyc(1);
      db_wr = 0;
      cyc(1);
      `CHK("db_rise_act", 12'h003, db_rise_act)
      cfg(8'h01);
      {db_rise_wdata, db_fall_wdata, db_wr} = {12'h009, 12'h00a, 1'b1};
      cyc(1);
      db_wr = 0;
      cyc(40);
      `CHK("db_rise_act", 12'h003, db_rise_act)
      global_sync_req = 1;
      cyc(1);
      global_sync_req = 0;
      `WAITV(db_fall_act == 12'h00a)
      `CHK("db_fall_act", 12'h00a, db_fall_act)
      fclr_wr = 1;
      cyc(1);
      {fclr_wr, freq} = {1'b0, 4'h1};
      cyc(1);
      `CHK("fault_active", 1'b1, fault_active)
      freq = 4'h0;
      cyc(2);
      `CHK("fault_status", 8'h01, fault_status)
      fclr_wr = 1;
      cyc(1);
      {fclr_wr, freq} = {1'b0, 4'h2};
      cyc(1);
      `CHK("fault_status", 8'h00, fault_status)
      `CHK("fault_active", 1'b0, fault_active)
      cfg(8'h14);
      {trig_wdata, trig_wr} = {8'h02, 1'b1};
      cyc(1);
      trig_wr = 0;
      `CHK("fault_active", 1'b1, fault_active)
      `CHK("fault_status", 8'h02, fault_status)
      freq = 4'h1;
      cyc(1);
      `CHK("fault_active", 1'b0, fault_active)
      {freq, trig_group, trig_wdata, trig_wr} = {4'h0, 1'b1, 8'h01, 1'b1};
      cyc(1);
      {trig_wr, dcmp_in, stat_group} = {1'b0, 8'h01, 1'b1};
      cyc(1);
      `CHK("fault_active", 1'b1, fault_active)
      `CHK("fault_status", 8'h01, fault_status)
      fcfg(4'he, 16'h0008);
      cfg(8'h18);
      freq = 4'h1;
      cyc(1);
      freq = 4'h0;
      cyc(4);
      `CHK("fault_active", 1'b1, fault_active)
      `CHK("fault_irq", 1'b1, fault_irq)
      cyc(40);
      `CHK("fault_active", 1'b0, fault_active)
      cfg_mode_sync = 2'h2;
      cfg(8'h80);
      `WAITV(count_dir_up)
      `CHK("count_dir_up", 1'b0, count_dir_up)
      global_sync_req = 1;
      cyc(1);
      global_sync_req = 0;
      `WAITV(count_dir_up)
      `CHK("count_dir_up", 1'b1, count_dir_up)
      test_done();
   end
endmodule : pwm_generator_counter_fault_ctrl_tb
